// *** adcc_top.sv ***
// converter control: registers over axi4-lite, sequencing, result formatting
`timescale 1ns/100ps
`include "adcc_map.svh"
module adcc_top (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [9:0] s_axi_awaddr,
	input wire logic [2:0] s_axi_awprot,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [9:0] s_axi_araddr,
	input wire logic [2:0] s_axi_arprot,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic sleep_mode,
	input wire logic [11:0] sar_result,
	output logic sar_sample,
	output logic sar_convert,
	output logic [4:0] channel_select,
	output logic internal_ref_regulator_on,
	output logic internal_ref_level_select,
	output logic done_irq
);
	adcc_tick_if tk ();
	adcc_pkg::adcc_state_t state_reg;
	logic [7:0] ctrl1_reg;
	logic [7:0] ctrl2_reg;
	logic [7:0] res_hi_reg;
	logic [7:0] res_lo_reg;
	logic done_reg;
	logic irq_en_reg;
	logic [5:0] tad_reg;
	logic [9:0] aw_reg;
	logic aw_ok_reg;
	logic [31:0] wd_reg;
	logic [3:0] ws_reg;
	logic wd_ok_reg;
	logic wr_go;
	logic [7:0] wr_byte;
	logic conv_end;
	logic abort;

	// write address and data captured independently, either order
	// one write at a time: both channels stay closed until the response is taken
	// the read channel is independent and may overlap a write
	assign s_axi_awready = !aw_ok_reg && !s_axi_bvalid;
	assign s_axi_wready = !wd_ok_reg && !s_axi_bvalid;
	assign wr_go = aw_ok_reg && wd_ok_reg;
	assign wr_byte = wd_reg[7:0];
	assign s_axi_arready = !s_axi_rvalid;
	assign s_axi_bresp = `ADCC_RESP_OKAY;

	// word index of a byte address; every register owns one whole 32-bit word
	// and sits in byte lane 0 of it, so software never has to merge lanes
	function automatic logic [7:0] index_of(input logic [9:0] a);
		index_of = a[9:2];
	endfunction

	// the six indices are contiguous, so one range test covers the map
	// unmapped reads answer with a slave error, unmapped writes are dropped
	function automatic logic mapped(input logic [9:0] a);
		logic [7:0] i;
		i = index_of(a);
		mapped = (i >= `ADCC_OFF_CTRL2) && (i <= `ADCC_OFF_ANALOG);
	endfunction

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_ok_reg <= 1'b0;
			aw_reg <= 10'h000;
		end else if (s_axi_awvalid && s_axi_awready) begin
			aw_ok_reg <= 1'b1;
			aw_reg <= s_axi_awaddr;
		end else if (wr_go) begin
			aw_ok_reg <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wd_ok_reg <= 1'b0;
			wd_reg <= 32'h00000000;
			ws_reg <= 4'h0;
		end else if (s_axi_wvalid && s_axi_wready) begin
			wd_ok_reg <= 1'b1;
			wd_reg <= s_axi_wdata;
			ws_reg <= s_axi_wstrb;
		end else if (wr_go) begin
			wd_ok_reg <= 1'b0;
		end
	end

	// response one cycle after both halves are in
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
		end else if (wr_go) begin
			s_axi_bvalid <= 1'b1;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// write strobes per register, lane 0 only; result registers take no writes
	// a write without lane 0 enabled is answered but changes nothing
	logic wr_c2;
	logic wr_c1;
	logic wr_stat;
	assign wr_c2 = wr_go && ws_reg[0] && (index_of(aw_reg) == `ADCC_OFF_CTRL2);
	assign wr_c1 = wr_go && ws_reg[0] && (index_of(aw_reg) == `ADCC_OFF_CTRL1);
	assign wr_stat = wr_go && ws_reg[0] && (index_of(aw_reg) == `ADCC_OFF_STAT);

	// second control register, byte lane 0
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl2_reg <= `ADCC_CTRL_RST;
		end else if (wr_c2) begin
			ctrl2_reg <= wr_byte & 8'hc5;
		end
	end

	// first control register; go is also driven by the sequencer
	// completion in the same cycle as a write still clears go
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl1_reg <= `ADCC_CTRL_RST;
		end else if (wr_c1) begin
			ctrl1_reg <= wr_byte;
			// go only takes when converter already on, never in the enabling write
			ctrl1_reg[`ADCC_BIT_GO] <= wr_byte[`ADCC_BIT_GO] && ctrl1_reg[`ADCC_BIT_ON]
				&& wr_byte[`ADCC_BIT_ON] && !sleep_mode && !conv_end;
		end else if (conv_end) begin
			ctrl1_reg[`ADCC_BIT_GO] <= 1'b0;
		end
	end

	// sticky done flag: completion wins over a clearing write
	// losing a completion would hang software waiting for the flag
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			done_reg <= 1'b0;
			irq_en_reg <= 1'b0;
		end else begin
			if (wr_stat) begin
				irq_en_reg <= wr_byte[`ADCC_BIT_IRQEN];
			end
			if (conv_end) begin
				done_reg <= 1'b1;
			end else if (wr_stat && wr_byte[`ADCC_BIT_DONE]) begin
				done_reg <= 1'b0;
			end
		end
	end

	// sequencer: convert for 49 periods, hold 2 periods after an abort
	// go, on and sleep are watched every cycle; go or on dropping, or sleep rising, aborts
	// the hold-off cannot be skipped, a new go waits in the register until idle
	// the divider is stopped in the abort cycle so the hold-off counts whole periods;
	// a partial first period would make the pause shorter than two bit periods,
	// and a dead tick there also keeps a late completion from loading results
	assign tk.run = state_reg != adcc_pkg::ADCC_IDLE && !abort;
	assign tk.sel = ctrl1_reg[`ADCC_CS_LO +: 2];
	assign conv_end = state_reg == adcc_pkg::ADCC_CONV && tk.tick &&
		tad_reg == 6'(`ADCC_CONV_TAD - 1) && ctrl1_reg[`ADCC_BIT_GO];
	// abort on go cleared, converter off or sleep
	assign abort = state_reg == adcc_pkg::ADCC_CONV && (!ctrl1_reg[`ADCC_BIT_GO] ||
		!ctrl1_reg[`ADCC_BIT_ON] || sleep_mode);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_reg <= adcc_pkg::ADCC_IDLE;
			tad_reg <= 6'h00;
		end else begin
			case (state_reg)
				adcc_pkg::ADCC_IDLE: begin
					tad_reg <= 6'h00;
					if (ctrl1_reg[`ADCC_BIT_GO] && ctrl1_reg[`ADCC_BIT_ON] && !sleep_mode) begin
						state_reg <= adcc_pkg::ADCC_CONV;
					end
				end
				adcc_pkg::ADCC_CONV: begin
					if (abort) begin
						state_reg <= adcc_pkg::ADCC_HOLD;
						tad_reg <= 6'h00;
					end else if (conv_end) begin
						state_reg <= adcc_pkg::ADCC_IDLE;
					end else if (tk.tick) begin
						tad_reg <= tad_reg + 6'h01;
					end
				end
				adcc_pkg::ADCC_HOLD: begin
					if (tk.tick) begin
						tad_reg <= tad_reg + 6'h01;
						if (tad_reg == 6'(`ADCC_ABORT_TAD - 1)) begin
							state_reg <= adcc_pkg::ADCC_IDLE;
						end
					end
				end
				default: state_reg <= adcc_pkg::ADCC_IDLE;
			endcase
		end
	end

	adcc_tad_div u_div (
		.aclk(aclk),
		.aresetn(aresetn),
		.t(tk)
	);

	// results change only on a finished conversion
	// an abort never reaches this branch, so old results survive it
	// the low two result bits are lost in right-aligned form
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			res_hi_reg <= 8'h00;
			res_lo_reg <= 8'h00;
		end else if (conv_end) begin
			if (ctrl2_reg[`ADCC_BIT_JUST]) begin
				res_hi_reg <= {6'h00, sar_result[11:10]};
				res_lo_reg <= sar_result[9:2];
			end else begin
				res_hi_reg <= sar_result[11:4];
				res_lo_reg <= {sar_result[3:0], 4'h0};
			end
		end
	end

	// acquisition runs whenever on, not asleep and not converting or holding off
	// after the hold-off it resumes by itself on the selected channel
	assign sar_sample = ctrl1_reg[`ADCC_BIT_ON] && !sleep_mode &&
		state_reg == adcc_pkg::ADCC_IDLE;
	assign sar_convert = state_reg == adcc_pkg::ADCC_CONV;
	// reserved codes above the reference code are passed through unchanged
	assign channel_select = {ctrl2_reg[`ADCC_BIT_CHTOP], ctrl1_reg[`ADCC_CH_LO +: 4]};
	assign internal_ref_regulator_on = ctrl2_reg[`ADCC_BIT_REGON];
	assign internal_ref_level_select = ctrl2_reg[`ADCC_BIT_REFLVL];
	assign done_irq = done_reg && irq_en_reg;

	// read path, registered data
	// each register reads back in bits 7:0 of its own word
	// reserved bits read as zero, so software may compare whole words
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= `ADCC_RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= mapped(s_axi_araddr) ? `ADCC_RESP_OKAY : `ADCC_RESP_SLVERR;
			case (index_of(s_axi_araddr))
				`ADCC_OFF_CTRL2: s_axi_rdata <= {24'h000000, ctrl2_reg};
				`ADCC_OFF_CTRL1: s_axi_rdata <= {24'h000000, ctrl1_reg};
				`ADCC_OFF_RESH: s_axi_rdata <= {24'h000000, res_hi_reg};
				`ADCC_OFF_RESL: s_axi_rdata <= {24'h000000, res_lo_reg};
				`ADCC_OFF_STAT: s_axi_rdata <= {30'h0, irq_en_reg, done_reg};
				`ADCC_OFF_ANALOG: s_axi_rdata <= {27'h0, channel_select};
				default: s_axi_rdata <= 32'h00000000;
			endcase
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end
endmodule

// *** adcc_map.svh ***
// register offsets, field positions, reset values and timing counts of the converter control
`ifndef ADCC_MAP_SVH
`define ADCC_MAP_SVH
`define ADCC_OFF_CTRL2 8'h9c
`define ADCC_OFF_CTRL1 8'h9d
`define ADCC_OFF_RESH 8'h9e
`define ADCC_OFF_RESL 8'h9f
// the register offsets above are word indices; the byte address is four times the index
`define ADCC_OFF_STAT 8'ha0
`define ADCC_OFF_ANALOG 8'ha1
`define ADCC_CTRL_RST 8'h00
`define ADCC_BIT_ON 0
`define ADCC_BIT_GO 1
`define ADCC_CH_LO 2
`define ADCC_CS_LO 6
`define ADCC_BIT_REFLVL 0
`define ADCC_BIT_REGON 2
`define ADCC_BIT_CHTOP 6
`define ADCC_BIT_JUST 7
`define ADCC_BIT_DONE 0
`define ADCC_BIT_IRQEN 1
`define ADCC_CONV_TAD 49
`define ADCC_ABORT_TAD 2
`define ADCC_CH_MAX 5'h12
`define ADCC_RESP_OKAY 2'h0
`define ADCC_RESP_SLVERR 2'h2
`endif

// *** adcc_pkg.sv ***
// types shared by the converter control
package adcc_pkg;
	typedef enum logic [1:0] {
		ADCC_IDLE = 2'b00,
		ADCC_CONV = 2'b01,
		ADCC_HOLD = 2'b11
	} adcc_state_t;
endpackage

// *** adcc_tick_if.sv ***
// conversion clock divider control and tick between control and divider
`timescale 1ns/100ps
interface adcc_tick_if;
	logic run;
	logic [1:0] sel;
	logic tick;
	modport ctrl (output run, output sel, input tick);
	modport div (input run, input sel, output tick);
endinterface

// *** adcc_tad_div.sv ***
// conversion clock divider producing one tick per bit-conversion period
`timescale 1ns/100ps
module adcc_tad_div (
	input wire logic aclk,
	input wire logic aresetn,
	adcc_tick_if.div t
);
	logic [6:0] cnt_reg;
	logic [6:0] last;
	// divide by 8, 16, 32 or 128
	always_comb begin
		case (t.sel)
			2'h0: last = 7'h07;
			2'h1: last = 7'h0f;
			2'h2: last = 7'h1f;
			default: last = 7'h7f;
		endcase
	end
	// restarts on every run so each period is whole
	always_ff @(posedge aclk) begin
		if (!aresetn || !t.run || cnt_reg == last) begin
			cnt_reg <= 7'h00;
		end else begin
			cnt_reg <= cnt_reg + 7'h01;
		end
	end
	assign t.tick = t.run && (cnt_reg == last);
endmodule

// *** adcc_sar_model.sv ***
// behavioural converter core behind the control block
`timescale 1ns/100ps
module adcc_sar_model (
	input wire logic aclk,
	input wire logic sar_convert,
	input wire logic [4:0] channel_select,
	output logic [11:0] sar_result
);
	// code tracks the channel; flips when idle so a stray load shows up
	always @(posedge aclk) begin
		if (sar_convert) begin
			sar_result <= {channel_select, 7'h2b};
		end else begin
			sar_result <= ~sar_result;
		end
	end
endmodule

// *** adcc_top_assertions.sv ***
// port checks of the converter control
`timescale 1ns/100ps
module adcc_chk (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic sleep_mode,
	input wire logic sar_sample,
	input wire logic sar_convert,
	input wire logic done_irq,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid
);
	localparam int CMIN = 384;
	logic [15:0] cnt;
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// run length of a conversion, kept until acquiring resumes
	always_ff @(posedge aclk) begin
		if (!aresetn || sar_sample) begin
			cnt <= 16'h0000;
		end else if (sar_convert) begin
			cnt <= cnt + 16'h0001;
		end
	end
	a_sleep_idle: assert property (sleep_mode |-> !sar_sample)
		else $error("sampling while asleep");
	a_sleep_stop: assert property (sleep_mode ##1 sleep_mode |-> !sar_convert)
		else $error("converting while asleep");
	a_conv_excl: assert property (sar_convert |-> !sar_sample)
		else $error("sample and convert together");
	a_conv_len: assert property ($rose(done_irq) |-> cnt >= CMIN && cnt <= 6400)
		else $error("conversion length out of range");
	a_abort_hold: assert property ($fell(sar_convert) && cnt < CMIN |-> !sar_sample [*8])
		else $error("acquisition too soon after abort");
	a_bresp_okay: assert property (s_axi_bvalid |-> s_axi_bresp == 2'h0)
		else $error("write response not okay");
	a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("write response dropped");
	a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
	a_read_refuse: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read taken while pending");
	c_done: cover property ($rose(done_irq));
	c_abort: cover property ($fell(sar_convert) && cnt < CMIN);
	c_sleep: cover property (sleep_mode ##1 sleep_mode);
endmodule
bind adcc_top adcc_chk u_chk (.aclk, .aresetn, .sleep_mode, .sar_sample, .sar_convert,
	.done_irq, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid,
	.s_axi_arready, .s_axi_rvalid);

// *** adcc_top_test.sv ***
// register level test of the converter control
`timescale 1ns/100ps
`define CHK(n, x, y) begin n_checks++; if ((y) !== (x)) begin err_total++; \
	$display("unexpected %s exp %h got %h", n, x, y); end end
module adcc_top_test;
	logic aclk = 1'b0, aresetn = 1'b0, awv = 1'b0, wv = 1'b0, bry = 1'b0;
	logic arv = 1'b0, rry = 1'b0, slp = 1'b0;
	localparam logic [9:0] A_C2 = 10'h270, A_C1 = 10'h274, A_RH = 10'h278;
	localparam logic [9:0] A_RL = 10'h27c, A_ST = 10'h280, A_BAD = 10'h2c0;
	logic [9:0] awa = 10'h000, ara = 10'h000;
	logic [15:0] r16;
	logic [31:0] wd = 32'h0, rdat, v;
	logic awr, wrr, bv, arr, rv, samp, conv, rg, lv, irq;
	logic [1:0] br, rr, e;
	logic [11:0] res;
	logic [4:0] ch;
	int err_total = 0, n_checks = 0, clen = 0, k, n, dv;
	always #2 aclk = ~aclk;
	// cycles spent converting, differenced per run
	always @(posedge aclk) if (conv) clen <= clen + 1;
	adcc_top uut (.aclk, .aresetn, .s_axi_awaddr(awa), .s_axi_awprot(3'h0),
		.s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hf),
		.s_axi_wvalid(wv), .s_axi_wready(wrr), .s_axi_bresp(br), .s_axi_bvalid(bv),
		.s_axi_bready(bry), .s_axi_araddr(ara), .s_axi_arprot(3'h0), .s_axi_arvalid(arv),
		.s_axi_arready(arr), .s_axi_rdata(rdat), .s_axi_rresp(rr), .s_axi_rvalid(rv),
		.s_axi_rready(rry), .sleep_mode(slp), .sar_result(res), .sar_sample(samp),
		.sar_convert(conv), .channel_select(ch), .internal_ref_regulator_on(rg),
		.internal_ref_level_select(lv), .done_irq(irq));
	adcc_sar_model sar (.aclk, .sar_convert(conv), .channel_select(ch), .sar_result(res));
	task automatic conclude;
		$display("checks %0d errors %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	task automatic stuck;
		err_total++;
		conclude;
	endtask
	// handshakes sampled at the falling edge, released after the rising one
	task automatic wr(input logic [9:0] a, input logic [31:0] d);
		logic ha, hw, hb;
		@(posedge aclk);
		awa <= a;
		wd <= d;
		awv <= 1'b1;
		wv <= 1'b1;
		bry <= 1'b1;
		for (int i = 0; i < 99; i++) begin
			@(negedge aclk);
			ha = awv && awr;
			hw = wv && wrr;
			hb = bv;
			@(posedge aclk);
			if (ha) awv <= 1'b0;
			if (hw) wv <= 1'b0;
			if (hb) begin
				bry <= 1'b0;
				return;
			end
		end
		stuck;
	endtask
	task automatic rd(input logic [9:0] a);
		logic ha, hr;
		@(posedge aclk);
		ara <= a;
		arv <= 1'b1;
		rry <= 1'b1;
		for (int i = 0; i < 99; i++) begin
			@(negedge aclk);
			ha = arv && arr;
			hr = rv;
			v = rdat;
			e = rr;
			@(posedge aclk);
			if (ha) arv <= 1'b0;
			if (hr) begin
				rry <= 1'b0;
				return;
			end
		end
		stuck;
	endtask
	task automatic ctl(input logic [7:0] c1, input logic [7:0] c2);
		wr(A_C2, {24'h0, c2});
		wr(A_C1, {24'h0, c1});
	endtask
	// {low, high} result bytes
	task automatic rres(output logic [15:0] r);
		rd(A_RH);
		r[7:0] = v[7:0];
		rd(A_RL);
		r[15:8] = v[7:0];
	endtask
	// software polls go until hardware drops it
	task automatic wait_go;
		for (int i = 0; i < 4000; i++) begin
			rd(A_C1);
			if (v[1] === 1'b0) return;
		end
		stuck;
	endtask
	// {low, high} result bytes for a justify setting
	function automatic logic [15:0] fmt(input logic [11:0] r, input logic j);
		return j ? {r[9:2], 6'h0, r[11:10]} : {r[3:0], 4'h0, r[11:4]};
	endfunction
	initial begin
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		rd(A_C2);
		`CHK("regs", 32'h0, v)
		rd(A_BAD);
		`CHK("rresp", 2'h2, e)
		ctl(8'h02, 8'h00);
		rd(A_C1);
		`CHK("off go", 1'b0, conv)
		`CHK("off go reg", 1'b0, v[1])
		ctl(8'h03, 8'h00);
		rd(A_C1);
		`CHK("on go", 2'b01, v[1:0])
		for (int c = 0; c < 20; c++) begin
			ctl({2'b00, c[3:0], 2'b01}, {1'b0, c[4], 6'h00});
			`CHK("chan", c[4:0], ch)
		end
		ctl(8'h01, 8'h05);
		`CHK("regu", 2'b11, {rg, lv})
		ctl(8'h01, 8'h04);
		`CHK("level", 1'b0, lv)
		repeat (50000) @(posedge aclk);
		for (int s = 0; s < 4; s++) begin
			ctl({s[1:0], 6'h09}, {s[0], 7'h40});
			wr(A_ST, {30'h0, s[1], 1'b1});
			k = clen;
			ctl({s[1:0], 6'h0b}, {s[0], 7'h40});
			rd(A_C1);
			`CHK("busy", 1'b1, v[1])
			wait_go;
			dv = (s == 3) ? 128 : 8 << s;
			`CHK("len", 1'b1, clen - k > 48 * dv && clen - k <= 49 * dv + 1)
			rres(r16);
			`CHK("res", fmt(12'h92b, s[0]), r16)
			rd(A_ST);
			`CHK("done", {s[1] == 1, 1'b1}, {irq, v[0]})
		end
		wr(A_ST, 32'h3);
		ctl(8'h0b, 8'hc0);
		repeat (40) @(posedge aclk);
		ctl(8'h09, 8'hc0);
		@(negedge aclk);
		`CHK("abort", 1'b0, conv)
		for (n = 0; n < 99 && samp !== 1'b1; n++) @(negedge aclk);
		`CHK("holdoff", 1'b1, n >= 15 && n <= 18)
		rres(r16);
		`CHK("kept", fmt(12'h92b, 1'b1), r16)
		rd(A_ST);
		`CHK("no done", 1'b0, v[0])
		ctl(8'h0b, 8'hc0);
		slp <= 1'b1;
		repeat (3) @(posedge aclk);
		ctl(8'h0b, 8'hc0);
		`CHK("sleep", 2'b00, {conv, samp})
		slp <= 1'b0;
		ctl(8'h01, 8'hc0);
		ctl(8'h0b, 8'hc0);
		@(negedge aclk);
		`CHK("run", 1'b1, conv)
		aresetn <= 1'b0;
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		`CHK("reset", 1'b0, conv)
		rd(A_C2);
		`CHK("reset regs", 32'h0, v)
		rd(A_C1);
		`CHK("reset ctrl1", 32'h0, v)
		conclude;
	end
endmodule
